// File: include/mcs_regs_regs.svh
// Register map, field positions, reset values and timing constants of the
// monitor configuration and status bank. Definitions only.
`ifndef MCS_REGS_REGS_SVH
`define MCS_REGS_REGS_SVH

// ==========================================================
// Register offsets
`define MCS_ADDR_CFG1      8'h40
`define MCS_ADDR_STAT1     8'h41
`define MCS_ADDR_CFG7      8'h11
`define MCS_ADDR_PMAX_LO   8'h38
`define MCS_ADDR_PMAX_HI   8'h3A

// ==========================================================
// Reset values
`define MCS_CFG1_RST       8'h04
`define MCS_STAT1_RST      8'h00

// ==========================================================
// Write masks of the configuration register
`define MCS_CFG_WMASK      8'h7B
`define MCS_CFG_LOCK_WMASK 8'h29

// ==========================================================
// Status field positions
`define MCS_ST_VOLT_LO     0
`define MCS_ST_TEMP_LO     4
`define MCS_ST_SUMMARY     7
`define MCS_N_VOLT         4
`define MCS_N_TEMP         3

// ==========================================================
// Fan and timing constants
`define MCS_N_FAN          3
`define MCS_PWM_FULL       8'hFF
`define MCS_BUS_TMO_MS     35
`define MCS_CLK_KHZ        100000
`define MCS_BUS_TMO_CYC    (`MCS_BUS_TMO_MS * `MCS_CLK_KHZ)
`define MCS_TMO_W          22
`define MCS_N_PIN          5

`endif

// File: include/mcs_pkg.sv
// Types shared by the monitor configuration and status bank.
// Assumes mcs_regs_regs.svh is compiled alongside for the numeric constants.
package mcs_pkg;

  // ==========================================================
  // Configuration register layout
  typedef struct packed {
    logic reserved;
    logic bus_timeout_enable;
    logic spinup_pulse_disable;
    logic vrm_current_flag;
    logic full_speed_force;
    logic ready;
    logic lock;
    logic monitor_run;
  } mcs_cfg_t;

  // ==========================================================
  // Out-of-limit conditions from the comparators
  typedef struct packed {
    logic [2:0] temp;
    logic [3:0] volt;
  } mcs_ool_t;

  // ==========================================================
  // State machines
  typedef enum logic [1:0] {
    MCS_SU_IDLE = 2'h0,
    MCS_SU_SPIN = 2'h1,
    MCS_SU_ONE  = 2'h3
  } mcs_spin_t;

  typedef enum logic [1:0] {
    MCS_BT_IDLE = 2'h0,
    MCS_BT_BUSY = 2'h1,
    MCS_BT_REL  = 2'h3
  } mcs_bus_t;

endpackage

// File: hw/mcs_sync3.sv
// Three-stage synchroniser for a pin from outside the clock domain.
// Assumes one clock; the output moves only when stages two and three agree.
`timescale 1ns/10ps
module mcs_sync3 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_i,
  output logic      sync_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================
  // Stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // Agreement filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_o <= 1'b0;
    end else if (s2_q == s3_q) begin
      sync_o <= s3_q;
    end
  end

endmodule

// File: hw/mcs_flag.sv
// One sticky out-of-limit status flag.
// Assumes cond_i and clr_i come from logic on the same clock.
`timescale 1ns/10ps
module mcs_flag (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cond_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_d;

  // ==========================================================
  // Set wins over clear, so a live condition never drops the flag.
  always_comb begin
    flag_d = cond_i | (flag_o & ~clr_i);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_d;
    end
  end

endmodule

// File: hw/mcs_top.sv
// Global configuration register and first interrupt status register of a
// fan controller and hardware monitor, with the fan drive and bus timeout
// control that these bits steer.
// Assumes a register port from the two-wire bus slave on the same clock,
// comparator results on the same clock, and raw tach and bus pins.
`timescale 1ns/10ps
`include "mcs_regs_regs.svh"
module mcs_top #(
  parameter logic [`MCS_TMO_W-1:0] BUS_TMO_CYC = `MCS_TMO_W'(`MCS_BUS_TMO_CYC)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_rvalid,
  output logic                  ext_wr_en,
  // Comparators and second status register
  input  wire mcs_pkg::mcs_ool_t status2_summary,
  input  wire logic             overtemp_pin_mode,
  input  wire logic             overtemp_timer_over,
  input  wire logic [7:0]       status2,
  // Fan drive
  input  wire logic [7:0]       pwm_auto_duty [`MCS_N_FAN],
  input  wire logic [7:0]       pwm_cur_duty  [`MCS_N_FAN],
  input  wire logic [`MCS_N_FAN-1:0] spinup_start,
  input  wire logic [`MCS_N_FAN-1:0] spinup_tmo,
  input  wire logic [`MCS_N_FAN-1:0] tach_pin,
  output logic      [7:0]       pwm_duty [`MCS_N_FAN],
  output logic      [`MCS_N_FAN-1:0] spinup_active,
  // Monitor control
  output mcs_pkg::mcs_cfg_t     cfg,
  output logic                  monitor_en,
  output logic                  use_default_limits,
  output logic                  lock_active,
  // Bus watchdog
  input  wire logic             scl_pin,
  input  wire logic             sda_pin,
  input  wire logic             bus_addressed,
  output logic                  bus_release
);

  // ==========================================================
  // Declarations
  mcs_pkg::mcs_cfg_t       cfg_q;
  mcs_pkg::mcs_cfg_t       cfg_d;
  logic [7:0]              wmask;
  logic [7:0]              stat;
  logic [6:0]              cond;
  logic                    stat_clr;
  logic [`MCS_N_PIN-1:0]   pin_raw;
  logic [`MCS_N_PIN-1:0]   pin_s;
  logic [`MCS_N_PIN-1:0]   pin_prev_q;
  logic [`MCS_N_PIN-1:0]   pin_edge;
  logic                    bus_activity;
  mcs_pkg::mcs_bus_t       bus_st_q;
  logic [`MCS_TMO_W-1:0]   idle_cnt_q;
  logic                    tmo_hit;
  localparam int           N_FLAG = `MCS_N_VOLT + `MCS_N_TEMP;

  // ==========================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  function automatic logic lockable(input logic [7:0] a);
    lockable = hit(a, `MCS_ADDR_CFG7) ||
               ((a >= `MCS_ADDR_PMAX_LO) && (a <= `MCS_ADDR_PMAX_HI));
  endfunction

  // ==========================================================
  // Configuration register
  // Once locked only the run, force and spin-up bits take writes.
  always_comb begin
    wmask = cfg_q.lock ? `MCS_CFG_LOCK_WMASK : `MCS_CFG_WMASK;
  end

  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr && hit(reg_addr, `MCS_ADDR_CFG1)) begin
      cfg_d = (cfg_q & ~wmask) | (reg_wdata & wmask);
      cfg_d.lock = cfg_q.lock | cfg_d.lock;
    end
    cfg_d.reserved = 1'b0;
    cfg_d.ready    = cfg_q.ready;
  end

  // The core reset is held by the supply monitor until power-up is
  // complete, so the ready flag is already valid when reset releases.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `MCS_CFG1_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg         = cfg_q;
  assign lock_active = cfg_q.lock;

  // ==========================================================
  // Lockable registers elsewhere
  // Limit registers are never touched here, so stopping the monitor
  // keeps whatever software programmed.
  always_comb begin
    ext_wr_en = reg_wr && !(cfg_q.lock && lockable(reg_addr));
  end

  // ==========================================================
  // Monitor run control
  always_comb begin
    monitor_en         = cfg_q.monitor_run;
    use_default_limits = !cfg_q.monitor_run;
  end

  // ==========================================================
  // Status sources
  always_comb begin
    cond = {status2_summary.temp, status2_summary.volt};
    if (overtemp_pin_mode) begin
      cond[`MCS_ST_VOLT_LO] = overtemp_timer_over;
    end
  end

  assign stat_clr = reg_rd && hit(reg_addr, `MCS_ADDR_STAT1);

  // ==========================================================
  // Sticky flags
  // A status read clears every flag whose condition has gone.
  genvar gi;
  generate
    for (gi = 0; gi < N_FLAG; gi++) begin : g_flag
      mcs_flag u_flag (
        .clk    (clk),
        .rst_n  (rst_n),
        .cond_i (cond[gi]),
        .clr_i  (stat_clr),
        .flag_o (stat[gi])
      );
    end
  endgenerate

  assign stat[`MCS_ST_SUMMARY] = |status2;

  // ==========================================================
  // Register read port
  // Read data is registered; writes to the status address are ignored.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `MCS_STAT1_RST;
    end else if (reg_rd) begin
      if (hit(reg_addr, `MCS_ADDR_CFG1)) begin
        reg_rdata <= cfg_q;
      end else if (stat_clr) begin
        reg_rdata <= stat;
      end else begin
        reg_rdata <= `MCS_STAT1_RST;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // Bus lines idle high while the synchronisers reset low; inverting them
  // here keeps the release of reset from looking like a line edge.
  assign pin_raw = {~sda_pin, ~scl_pin, tach_pin};

  generate
    for (gi = 0; gi < `MCS_N_PIN; gi++) begin : g_sync
      mcs_sync3 u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pin_i  (pin_raw[gi]),
        .sync_o (pin_s[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_s;
    end
  end

  assign pin_edge     = pin_s ^ pin_prev_q;
  assign bus_activity = |pin_edge[`MCS_N_PIN-1:`MCS_N_FAN];

  // ==========================================================
  // Fan spin-up
  // Normally spin-up ends on the second rising tach edge; with pulse
  // detection off it runs until the selected timeout instead.
  generate
    for (gi = 0; gi < `MCS_N_FAN; gi++) begin : g_spin
      mcs_pkg::mcs_spin_t su_q;
      logic               tach_rise;

      assign tach_rise = pin_edge[gi] && pin_s[gi];

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          su_q <= mcs_pkg::MCS_SU_IDLE;
        end else begin
          case (su_q)
            mcs_pkg::MCS_SU_IDLE: begin
              if (spinup_start[gi]) begin
                su_q <= mcs_pkg::MCS_SU_SPIN;
              end
            end
            mcs_pkg::MCS_SU_SPIN: begin
              if (spinup_tmo[gi]) begin
                su_q <= mcs_pkg::MCS_SU_IDLE;
              end else if (tach_rise && !cfg_q.spinup_pulse_disable) begin
                su_q <= mcs_pkg::MCS_SU_ONE;
              end
            end
            mcs_pkg::MCS_SU_ONE: begin
              if (spinup_tmo[gi]) begin
                su_q <= mcs_pkg::MCS_SU_IDLE;
              end else if (tach_rise && !cfg_q.spinup_pulse_disable) begin
                su_q <= mcs_pkg::MCS_SU_IDLE;
              end
            end
            default: begin
              su_q <= mcs_pkg::MCS_SU_IDLE;
            end
          endcase
        end
      end

      assign spinup_active[gi] = (su_q != mcs_pkg::MCS_SU_IDLE);
    end
  endgenerate

  // ==========================================================
  // PWM duty selection
  // Thermal protection outranks everything: a stopped monitor means full
  // duty even if software asked for a quieter setting.
  generate
    for (gi = 0; gi < `MCS_N_FAN; gi++) begin : g_pwm
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pwm_duty[gi] <= `MCS_PWM_FULL;
        end else if (!cfg_q.monitor_run) begin
          pwm_duty[gi] <= `MCS_PWM_FULL;
        end else if (spinup_active[gi]) begin
          pwm_duty[gi] <= `MCS_PWM_FULL;
        end else if (cfg_q.full_speed_force) begin
          pwm_duty[gi] <= pwm_cur_duty[gi];
        end else begin
          pwm_duty[gi] <= pwm_auto_duty[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Bus watchdog
  // The count restarts on every line edge, so only a stall inside a
  // transaction addressed to this device can trip it.
  // The count saturates, so a limit reached while the timeout is disabled
  // releases the bus as soon as the timeout is enabled.
  assign tmo_hit = (idle_cnt_q >= BUS_TMO_CYC);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= '0;
    end else if (bus_st_q != mcs_pkg::MCS_BT_BUSY || bus_activity) begin
      idle_cnt_q <= '0;
    end else if (!tmo_hit) begin
      idle_cnt_q <= idle_cnt_q + `MCS_TMO_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_st_q <= mcs_pkg::MCS_BT_IDLE;
    end else begin
      case (bus_st_q)
        mcs_pkg::MCS_BT_IDLE: begin
          if (bus_addressed) begin
            bus_st_q <= mcs_pkg::MCS_BT_BUSY;
          end
        end
        mcs_pkg::MCS_BT_BUSY: begin
          if (!bus_addressed) begin
            bus_st_q <= mcs_pkg::MCS_BT_IDLE;
          end else if (tmo_hit && cfg_q.bus_timeout_enable) begin
            bus_st_q <= mcs_pkg::MCS_BT_REL;
          end
        end
        mcs_pkg::MCS_BT_REL: begin
          if (!bus_addressed) begin
            bus_st_q <= mcs_pkg::MCS_BT_IDLE;
          end
        end
        default: begin
          bus_st_q <= mcs_pkg::MCS_BT_IDLE;
        end
      endcase
    end
  end

  assign bus_release = (bus_st_q == mcs_pkg::MCS_BT_REL);

endmodule

// File: test/mcs_top_props.sv
// Concurrent checks on the ports of the monitor configuration bank.
// Assumes it is bound into mcs_top and sees only its ports.
`timescale 1ns/10ps
module mcs_top_props (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              reg_rvalid,
  input wire logic              ext_wr_en,
  input wire mcs_pkg::mcs_ool_t status2_summary,
  input wire logic [7:0]        status2,
  input wire logic [7:0]        pwm_cur_duty [3],
  input wire logic [7:0]        pwm_duty [3],
  input wire logic [2:0]        spinup_start,
  input wire logic [2:0]        spinup_tmo,
  input wire logic [2:0]        spinup_active,
  input wire mcs_pkg::mcs_cfg_t cfg,
  input wire logic              monitor_en,
  input wire logic              use_default_limits,
  input wire logic              lock_active,
  input wire logic              bus_addressed,
  input wire logic              bus_release
);
  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_run_mirror: assert property (
    monitor_en == cfg.monitor_run && use_default_limits == !monitor_en)
    else $error("run outputs disagree");
  chk_ready_set: assert property (cfg.ready)
    else $error("ready flag low");
  chk_lock_hold: assert property ($past(cfg.lock) |-> cfg.lock)
    else $error("lock cleared");
  chk_lock_gate: assert property (
    lock_active && reg_wr && reg_addr >= 8'h38 && reg_addr <= 8'h3A |-> !ext_wr_en)
    else $error("locked write passed");
  chk_open_pass: assert property (!lock_active && reg_wr |-> ext_wr_en)
    else $error("open write blocked");
  chk_idle_full: assert property (
    !cfg.monitor_run |=> pwm_duty[0] == 8'hFF && pwm_duty[1] == 8'hFF && pwm_duty[2] == 8'hFF)
    else $error("duty not full while stopped");
  chk_force_duty: assert property (
    cfg.monitor_run && cfg.full_speed_force && !spinup_active[0]
    |=> pwm_duty[0] == $past(pwm_cur_duty[0]))
    else $error("forced duty wrong");
  chk_summary_or: assert property (
    reg_rd && reg_addr == 8'h41 |=> reg_rdata[7] == |$past(status2))
    else $error("summary bit wrong");
  chk_live_keeps: assert property (
    status2_summary.volt[1] && reg_rd && reg_addr == 8'h41 ##1 reg_rd && reg_addr == 8'h41 |=> reg_rdata[1])
    else $error("live flag dropped");
  chk_spin_end: assert property (
    spinup_active[0] && spinup_tmo[0] && !spinup_start[0] |=> !spinup_active[0])
    else $error("spin-up outlived timeout");
  chk_release_cause: assert property (
    $rose(bus_release) |-> $past(cfg.bus_timeout_enable) && bus_addressed)
    else $error("release without cause");
endmodule
bind mcs_top mcs_top_props u_mcs_top_props (
  .clk                (clk),
  .rst_n              (rst_n),
  .reg_addr           (reg_addr),
  .reg_wr             (reg_wr),
  .reg_rd             (reg_rd),
  .reg_rdata          (reg_rdata),
  .reg_rvalid         (reg_rvalid),
  .ext_wr_en          (ext_wr_en),
  .status2_summary                (status2_summary),
  .status2            (status2),
  .pwm_cur_duty       (pwm_cur_duty),
  .pwm_duty           (pwm_duty),
  .spinup_start       (spinup_start),
  .spinup_tmo         (spinup_tmo),
  .spinup_active      (spinup_active),
  .cfg                (cfg),
  .monitor_en         (monitor_en),
  .use_default_limits (use_default_limits),
  .lock_active        (lock_active),
  .bus_addressed      (bus_addressed),
  .bus_release        (bus_release)
);

// File: test/mcs_host_model.sv
// Register-port host: replays queued accesses, one per clock.
// Assumes the bench queues accesses with push; idle lines keep changing.
`timescale 1ns/10ps
module mcs_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  logic [16:0] q [$];
  task automatic push(input logic wr, input logic [7:0] a, input logic [7:0] d);
    q.push_back({wr, a, d & 8'h7F});
  endtask
  // Idle address and data invert so a stale value is never mistaken for a request.
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 8'h00;
    end else if (q.size() > 0) begin
      {reg_wr, reg_addr, reg_wdata} <= q[0];
      reg_rd <= !q[0][16];
      q.pop_front();
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
    end
  end
endmodule

// File: test/mcs_top_test.sv
// Self-checking bench for the monitor configuration and status bank.
// Assumes the host model drives the register port and the checker is bound.
`timescale 1ns/10ps
module mcs_top_test;
  logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, ot_mode, ot_over, scl, sda, bus_on, bus_rel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, status2;
  logic [7:0] auto_d [3];
  logic [7:0] cur_d [3];
  logic [7:0] duty [3];
  logic [2:0] spin_st, spin_to, tach, spin_act;
  mcs_pkg::mcs_ool_t status2_summary;
  logic [7:0] eq [$];
  int n_errors;
  int cmp_count;
  mcs_host_model u_mcs_host_model (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  mcs_top #(.BUS_TMO_CYC(22'h32)) u_mcs_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ext_wr_en(), .status2_summary(status2_summary), .overtemp_pin_mode(ot_mode),
    .overtemp_timer_over(ot_over), .status2(status2), .pwm_auto_duty(auto_d),
    .pwm_cur_duty(cur_d), .spinup_start(spin_st), .spinup_tmo(spin_to), .tach_pin(tach),
    .pwm_duty(duty), .spinup_active(spin_act), .cfg(), .monitor_en(),
    .use_default_limits(), .lock_active(), .scl_pin(scl), .sda_pin(sda),
    .bus_addressed(bus_on), .bus_release(bus_rel));
  // ==========================================================
  // Tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_mcs_host_model.push(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_mcs_host_model.push(1'b0, a, 8'h00);
    eq.push_back(e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait: a lost read answer shows up as leftover notes, not a hang.
  task automatic settle();
    int k;
    k = 0;
    while ((u_mcs_host_model.q.size() > 0 || eq.size() > 0) && k < 100) begin
      @(posedge clk);
      k++;
    end
    chk8(8'(eq.size()), 8'h00, "reads unanswered");
    cyc(4);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock, result monitor, watchdog
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (eq.size() == 0) chk8(reg_rdata, 8'hXX, "unexpected read");
      else begin
        chk8(reg_rdata, eq[0], "read data");
        void'(eq.pop_front());
      end
    end
  end
  initial begin
    #100us;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
  // ==========================================================
  // Tests
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    status2_summary = '0;
    ot_mode = 1'b0;
    ot_over = 1'b0;
    status2 = 8'h00;
    spin_st = 3'h0;
    spin_to = 3'h0;
    tach = 3'h0;
    scl = 1'b1;
    sda = 1'b1;
    bus_on = 1'b0;
    void'($urandom(84));
    for (int i = 0; i < 3; i++) begin
      auto_d[i] = 8'($urandom);
      cur_d[i] = 8'($urandom);
    end
    cyc(5);
    rst_n <= 1'b1;
    rd(8'h40, 8'h04);
    rd(8'h41, 8'h00);
    wr(8'h41, 8'hFF);
    rd(8'h41, 8'h00);
    settle();
    $display("reset and map test done");
    wr(8'h40, 8'h09);
    rd(8'h40, 8'h0D);
    settle();
    chk8(duty[0], cur_d[0], "forced duty");
    wr(8'h40, 8'h01);
    settle();
    chk8(duty[1], auto_d[1], "run duty");
    wr(8'h40, 8'h00);
    rd(8'h40, 8'h04);
    settle();
    chk8(duty[2], 8'hFF, "stopped duty");
    $display("fan drive test done");
    status2_summary <= 7'h56;
    cyc(3);
    rd(8'h41, 8'h56);
    rd(8'h41, 8'h56);
    settle();
    status2_summary <= '0;
    cyc(3);
    rd(8'h41, 8'h56);
    rd(8'h41, 8'h00);
    settle();
    status2 <= 8'($urandom) | 8'h01;
    cyc(2);
    rd(8'h41, 8'h80);
    settle();
    status2 <= 8'h00;
    ot_mode <= 1'b1;
    status2_summary <= 7'h01;
    cyc(3);
    rd(8'h41, 8'h00);
    settle();
    ot_over <= 1'b1;
    cyc(2);
    ot_over <= 1'b0;
    cyc(2);
    rd(8'h41, 8'h01);
    rd(8'h41, 8'h00);
    settle();
    ot_mode <= 1'b0;
    status2_summary <= '0;
    $display("status test done");
    wr(8'h40, 8'h21);
    settle();
    spin_st <= 3'h1;
    cyc(1);
    spin_st <= 3'h0;
    repeat (10) begin
      cyc(4);
      tach <= tach ^ 3'h1;
    end
    chk8({7'h00, spin_act[0]}, 8'h01, "spin-up ended early");
    chk8(duty[0], 8'hFF, "spin duty not full");
    spin_to <= 3'h1;
    cyc(1);
    spin_to <= 3'h0;
    cyc(2);
    chk8({7'h00, spin_act[0]}, 8'h00, "spin-up not ended");
    wr(8'h40, 8'h01);
    settle();
    spin_st <= 3'h1;
    cyc(1);
    spin_st <= 3'h0;
    repeat (6) begin
      cyc(8);
      tach <= tach ^ 3'h1;
    end
    cyc(10);
    chk8({7'h00, spin_act[0]}, 8'h00, "tach end missing");
    $display("spin-up test done");
    wr(8'h40, 8'h41);
    settle();
    bus_on <= 1'b1;
    repeat (2) begin
      cyc(35);
      sda <= ~sda;
      cyc(35);
      scl <= ~scl;
    end
    chk8({7'h00, bus_rel}, 8'h00, "released while active");
    cyc(70);
    chk8({7'h00, bus_rel}, 8'h01, "bus not released");
    bus_on <= 1'b0;
    cyc(3);
    chk8({7'h00, bus_rel}, 8'h00, "release held");
    wr(8'h40, 8'h01);
    settle();
    bus_on <= 1'b1;
    cyc(70);
    chk8({7'h00, bus_rel}, 8'h00, "release when disabled");
    bus_on <= 1'b0;
    $display("bus timeout test done");
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h7F);
    wr(8'h40, 8'h00);
    rd(8'h40, 8'h56);
    wr(8'h40, 8'h08);
    rd(8'h40, 8'h5E);
    wr(8'h38, 8'h00);
    settle();
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    rd(8'h40, 8'h04);
    settle();
    $display("lock test done");
    end_of_test();
  end
endmodule
